// ---- rtl/sadc_defs.vh ----
// Constants for the serial converter control block: register map, field
// positions, reset values and control byte layout.
// Assumes inclusion by bare name from the design files.
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// Register byte addresses
`define SADC_ADDR_CTRL       8'h00
`define SADC_ADDR_STATUS     8'h04
`define SADC_ADDR_RESULT     8'h08
`define SADC_ADDR_INT_STATUS 8'h0C
`define SADC_ADDR_INT_MASK   8'h10
`define SADC_ADDR_W          8

// Reset values
`define SADC_CTRL_RST        1'h1
`define SADC_MASK_RST        3'h0
`define SADC_WORD_ZERO       32'h0000_0000
// Synchroniser reset levels: chip select idles high (deselected)
`define SADC_SYNC_RST        6'h01

// Bus responses
`define SADC_RESP_OKAY       2'h0
`define SADC_RESP_SLVERR     2'h2

// Interrupt status bits
`define SADC_INT_BYTE        0
`define SADC_INT_DONE        1
`define SADC_INT_SHUTDOWN_INPUT        2
`define SADC_INT_W           3

// Control byte fields
`define SADC_CB_CHAN_HI      6
`define SADC_CB_CHAN_LO      4
`define SADC_CB_POLARITY     3
`define SADC_CB_SINGLE       2
`define SADC_CB_PD_HI        1
`define SADC_CB_PD_LO        0
`define SADC_CB_TRACK_BITS   4'h5
`define SADC_CB_LAST_BIT     4'h8
`define SADC_CB_START_CNT    4'h1

// Power mode codes
`define SADC_MODE_EXT        2'h3
`define SADC_MODE_INT        2'h2

// Result layout
`define SADC_RES_MSB         4'h9
`define SADC_RES_FIRST_TRY   10'h200

`endif

// ---- rtl/sadc_sync.v ----
// Two flip-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; only the second stage is visible.
`timescale 1ns/10ps
`default_nettype none

module sadc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VALUE = {WIDTH{1'b0}}
) (
  input wire i_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] stage1;

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      stage1 <= RST_VALUE;
      o_sync <= RST_VALUE;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/sadc_top.v ----
// Serial control and data interface of an eight-channel 10-bit SAR converter,
// with an AXI4-Lite register slave and a level interrupt.
// Assumes the serial pins, comparator and shutdown detectors are asynchronous
// to I_CLK and change slower than a few I_CLK periods.
//
// Function
// - Serial input bits are taken on each rising serial clock edge.
// - Serial output changes on falling serial clock edges and when a conversion completes.
// - Serial output is high impedance while chip select is high.
// - Serial input is ignored while chip select is high.
// - Internal clock mode: strobe low at conversion start, high when done.
// - External clock mode: strobe high one serial clock period before MSB decision.
// - External clock mode: strobe high impedance while chip select is high.
// - Shutdown input low shuts the converter down; otherwise fully operational.
// - Shutdown input high selects internal reference compensation.
// - Shutdown input floating selects external reference compensation.
// - External clock mode: serial clock paces each approximation step.
// - Ten-bit result by successive approximation after a track and hold.
// - Conversion time is step count times conversion clock period.
// - Track starts on the falling edge after the fifth control bit.
// - Hold starts on the falling edge after the eighth control bit.
// - Three channel select bits choose the converted channel.
// - Polarity bit one means unipolar, zero means bipolar.
`timescale 1ns/10ps
`default_nettype none
`include "sadc_defs.vh"

module sadc_top #(
  parameter STEP_CYCLES = 8,
  parameter RES_BITS = 10
) (
  input wire I_CLK,
  input wire I_RST,
  input wire [7:0] I_AWADDR,
  input wire I_AWVALID,
  output reg O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output reg O_WREADY,
  output reg [1:0] O_BRESP,
  output reg O_BVALID,
  input wire I_BREADY,
  input wire [7:0] I_ARADDR,
  input wire I_ARVALID,
  output reg O_ARREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  output reg O_RVALID,
  input wire I_RREADY,
  output reg O_IRQ,
  input wire I_CHIP_SELECT_N,
  input wire I_SERIAL_CLOCK,
  input wire I_SERIAL_IN,
  output reg O_SERIAL_OUT,
  output reg O_SERIAL_OUT_OE_N,
  output reg O_CONVERSION_STROBE,
  output reg O_CONVERSION_STROBE_OE_N,
  input wire I_SHUTDOWN_INPUT_LOW,
  input wire I_SHUTDOWN_INPUT_HIGH,
  input wire I_COMPARATOR,
  output reg O_SHUTDOWN,
  output reg O_REF_INTERNAL_COMP,
  output reg O_TRACK_HOLD,
  output reg [2:0] O_CHANNEL_SELECT,
  output reg O_UNIPOLAR,
  output reg O_SINGLE_ENDED,
  output reg [RES_BITS-1:0] O_DAC_CODE
);

  localparam ST_IDLE = 2'b00;
  localparam ST_INT_CONV = 2'b01;
  localparam ST_EXT_STROBE = 2'b10;
  localparam ST_EXT_CONV = 2'b11;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and serial clock edges

  wire [5:0] sync_out;
  wire cs_n_s;
  wire sclk_s;
  wire sin_s;
  wire shutdown_input_low_s;
  wire shutdown_input_high_s;
  wire comp_s;
  reg sclk_d;
  wire sclk_rise;
  wire sclk_fall;
  reg ctrl_enable;
  wire link_off;

  // Reset to the idle pin levels so no false select follows reset
  sadc_sync #(
    .WIDTH(6),
    .RST_VALUE(`SADC_SYNC_RST)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_async({I_COMPARATOR, I_SHUTDOWN_INPUT_HIGH, I_SHUTDOWN_INPUT_LOW,
              I_SERIAL_IN, I_SERIAL_CLOCK, I_CHIP_SELECT_N}),
    .o_sync(sync_out)
  );

  assign cs_n_s = sync_out[0];
  assign sclk_s = sync_out[1];
  assign sin_s = sync_out[2];
  assign shutdown_input_low_s = sync_out[3];
  assign shutdown_input_high_s = sync_out[4];
  assign comp_s = sync_out[5];
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  // Deselected or disabled link behaves like chip select high
  assign link_off = cs_n_s | ~ctrl_enable | shutdown_input_low_s;

  always @(posedge I_CLK)
  begin
    if (I_RST)
      sclk_d <= 1'b0;
    else
      sclk_d <= sclk_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control byte receiver

  reg [3:0] rx_cnt;
  reg [6:0] rx_shift;
  reg [1:0] mode;
  reg [1:0] state;
  wire rx_active;
  wire byte_done;

  assign rx_active = ~link_off & (state != ST_INT_CONV) & (state != ST_EXT_CONV)
                     & (state != ST_EXT_STROBE);
  assign byte_done = rx_active & sclk_fall & (rx_cnt == `SADC_CB_LAST_BIT);

  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      rx_cnt <= 4'h0;
      rx_shift <= 7'h00;
    end
    else if (!rx_active)
      rx_cnt <= 4'h0;
    else if (byte_done)
      rx_cnt <= 4'h0;
    else if (sclk_rise)
    begin
      if (rx_cnt == 4'h0)
      begin
        if (sin_s)
          rx_cnt <= `SADC_CB_START_CNT;
      end
      else if (rx_cnt != `SADC_CB_LAST_BIT)
      begin
        rx_shift <= {rx_shift[5:0], sin_s};
        rx_cnt <= rx_cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Track and hold, control fields, shutdown and reference mode

  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_TRACK_HOLD <= 1'b0;
      O_CHANNEL_SELECT <= 3'h0;
      O_UNIPOLAR <= 1'b0;
      O_SINGLE_ENDED <= 1'b0;
      mode <= `SADC_MODE_INT;
      O_SHUTDOWN <= 1'b0;
      O_REF_INTERNAL_COMP <= 1'b0;
    end
    else
    begin
      O_SHUTDOWN <= shutdown_input_low_s;
      O_REF_INTERNAL_COMP <= shutdown_input_high_s & ~shutdown_input_low_s;
      if (rx_active & sclk_fall & (rx_cnt == `SADC_CB_TRACK_BITS))
        O_TRACK_HOLD <= 1'b1;
      else if (byte_done)
      begin
        O_TRACK_HOLD <= 1'b0;
        O_CHANNEL_SELECT <= rx_shift[`SADC_CB_CHAN_HI:`SADC_CB_CHAN_LO];
        O_UNIPOLAR <= rx_shift[`SADC_CB_POLARITY];
        O_SINGLE_ENDED <= rx_shift[`SADC_CB_SINGLE];
        mode <= rx_shift[`SADC_CB_PD_HI:`SADC_CB_PD_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Successive approximation engine

  reg [3:0] bit_idx;
  reg [15:0] step_cnt;
  reg conv_done;
  reg [RES_BITS-1:0] result;
  wire step_now;
  wire [RES_BITS-1:0] one_hot;
  wire [RES_BITS-1:0] decided;

  assign one_hot = {{(RES_BITS-1){1'b0}}, 1'b1} << bit_idx;
  assign decided = comp_s ? O_DAC_CODE : (O_DAC_CODE & ~one_hot);
  // Internal mode steps on a divided I_CLK, external mode on serial falls
  assign step_now = (state == ST_INT_CONV) ? (step_cnt == 16'h0000)
                    : (state == ST_EXT_CONV) & sclk_fall;

  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state <= ST_IDLE;
      bit_idx <= 4'h0;
      step_cnt <= 16'h0000;
      conv_done <= 1'b0;
      result <= {RES_BITS{1'b0}};
      O_DAC_CODE <= {RES_BITS{1'b0}};
      O_CONVERSION_STROBE <= 1'b1;
    end
    else
    begin
      conv_done <= 1'b0;
      if (state == ST_INT_CONV)
        step_cnt <= (step_cnt == 16'h0000) ? STEP_CYCLES[15:0] - 16'h0001
                    : step_cnt - 16'h0001;
      if (shutdown_input_low_s)
      begin
        state <= ST_IDLE;
        O_CONVERSION_STROBE <= 1'b1;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (byte_done & (rx_shift[1:0] == `SADC_MODE_EXT))
            begin
              state <= ST_EXT_STROBE;
              O_CONVERSION_STROBE <= 1'b1;
            end
            else if (byte_done & (rx_shift[1:0] == `SADC_MODE_INT))
            begin
              state <= ST_INT_CONV;
              step_cnt <= STEP_CYCLES[15:0] - 16'h0001;
              O_CONVERSION_STROBE <= 1'b0;
            end
            else if (mode == `SADC_MODE_EXT)
              O_CONVERSION_STROBE <= 1'b0;
            else
              O_CONVERSION_STROBE <= 1'b1;
            bit_idx <= `SADC_RES_MSB;
            O_DAC_CODE <= `SADC_RES_FIRST_TRY;
          end
          ST_EXT_STROBE:
          begin
            if (cs_n_s)
              state <= ST_IDLE;
            else if (sclk_fall)
            begin
              O_CONVERSION_STROBE <= 1'b0;
              state <= ST_EXT_CONV;
            end
          end
          ST_INT_CONV, ST_EXT_CONV:
          begin
            if ((state == ST_EXT_CONV) & cs_n_s)
              state <= ST_IDLE;
            else if (step_now)
            begin
              if (bit_idx == 4'h0)
              begin
                result <= decided;
                conv_done <= 1'b1;
                state <= ST_IDLE;
                if (state == ST_INT_CONV)
                  O_CONVERSION_STROBE <= 1'b1;
              end
              else
              begin
                O_DAC_CODE <= decided | (one_hot >> 1);
                bit_idx <= bit_idx - 4'h1;
              end
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result shifter and pin drivers

  reg [RES_BITS-1:0] out_shift;

  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      out_shift <= {RES_BITS{1'b0}};
      O_SERIAL_OUT <= 1'b0;
      O_SERIAL_OUT_OE_N <= 1'b1;
      O_CONVERSION_STROBE_OE_N <= 1'b1;
    end
    else
    begin
      O_SERIAL_OUT_OE_N <= cs_n_s;
      if (mode == `SADC_MODE_EXT)
        O_CONVERSION_STROBE_OE_N <= cs_n_s;
      else
        O_CONVERSION_STROBE_OE_N <= 1'b0;
      if (conv_done)
      begin
        O_SERIAL_OUT <= result[RES_BITS-1];
        out_shift <= {result[RES_BITS-2:0], 1'b0};
      end
      else if (sclk_fall & ~cs_n_s)
      begin
        O_SERIAL_OUT <= out_shift[RES_BITS-1];
        out_shift <= {out_shift[RES_BITS-2:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register slave and interrupt

  reg aw_full;
  reg w_full;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [2:0] int_mask;
  reg [2:0] int_status;
  reg shutdown_input_d;
  wire [2:0] int_events;
  wire rd_take;
  wire rd_clear;
  wire wr_do;

  assign rd_take = I_ARVALID & O_ARREADY;
  assign rd_clear = rd_take & (I_ARADDR == `SADC_ADDR_INT_STATUS);
  assign wr_do = aw_full & w_full & ~O_BVALID;
  assign int_events = {shutdown_input_low_s & ~shutdown_input_d, conv_done, byte_done};

  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `SADC_RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= `SADC_WORD_ZERO;
      w_strb <= 4'h0;
      ctrl_enable <= `SADC_CTRL_RST;
      int_mask <= `SADC_MASK_RST;
    end
    else
    begin
      if (I_AWVALID & O_AWREADY)
      begin
        aw_full <= 1'b1;
        aw_addr <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID & O_WREADY)
      begin
        w_full <= 1'b1;
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (wr_do)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= `SADC_RESP_OKAY;
        case (aw_addr)
          `SADC_ADDR_CTRL:
            if (w_strb[0])
              ctrl_enable <= w_data[0];
          `SADC_ADDR_INT_MASK:
            if (w_strb[0])
              int_mask <= w_data[`SADC_INT_W-1:0];
          `SADC_ADDR_STATUS, `SADC_ADDR_RESULT, `SADC_ADDR_INT_STATUS:
            O_BRESP <= `SADC_RESP_OKAY;
          default:
            O_BRESP <= `SADC_RESP_SLVERR;
        endcase
      end
      if (O_BVALID & I_BREADY)
      begin
        O_BVALID <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end

  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= `SADC_WORD_ZERO;
      O_RRESP <= `SADC_RESP_OKAY;
      int_status <= 3'h0;
      shutdown_input_d <= 1'b0;
      O_IRQ <= 1'b0;
    end
    else
    begin
      shutdown_input_d <= shutdown_input_low_s;
      // A new event wins over the clear by read
      int_status <= (int_status & ~(rd_clear ? 3'h7 : 3'h0)) | int_events;
      O_IRQ <= |(int_status & int_mask);
      if (rd_take)
      begin
        O_ARREADY <= 1'b0;
        O_RVALID <= 1'b1;
        O_RRESP <= `SADC_RESP_OKAY;
        case (I_ARADDR)
          `SADC_ADDR_CTRL:
            O_RDATA <= {31'h0000_0000, ctrl_enable};
          `SADC_ADDR_STATUS:
            O_RDATA <= {20'h0_0000, O_REF_INTERNAL_COMP, O_SHUTDOWN, O_TRACK_HOLD,
                        O_SINGLE_ENDED, O_UNIPOLAR, O_CHANNEL_SELECT, mode, state};
          `SADC_ADDR_RESULT:
            O_RDATA <= {{(32-RES_BITS){1'b0}}, result};
          `SADC_ADDR_INT_STATUS:
            O_RDATA <= {29'h0000_0000, int_status};
          `SADC_ADDR_INT_MASK:
            O_RDATA <= {29'h0000_0000, int_mask};
          default:
          begin
            O_RDATA <= `SADC_WORD_ZERO;
            O_RRESP <= `SADC_RESP_SLVERR;
          end
        endcase
      end
      if (O_RVALID & I_RREADY)
      begin
        O_RVALID <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- test/sadc_host.sv ----
// Host serial port model: chip select, serial clock and serial input.
// Assumes the bench calls its tasks one after another.
`timescale 1ns/10ps
`default_nettype none

module sadc_host (
  output var logic cs_n,
  output var logic sclk,
  output var logic din,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic strb,
  input wire logic strb_oe_n
);
  initial
  begin
    cs_n = 1'h1;
    sclk = 1'h0;
    din = 1'h0;
  end

  // Select moves while the clock idles low; released data line flips
  task cs(input logic v);
    begin
      #7;
      cs_n = v;
      if (v)
        din = ~din;
      #100;
    end
  endtask

  // One 200 ns period; outputs are read late in the high phase
  task cyc(input logic d, output logic q, output logic s);
    begin
      din = d;
      #100;
      sclk = 1'h1;
      #100;
      q = dout_oe_n ? 1'hx : dout;
      s = strb_oe_n ? 1'hx : strb;
      sclk = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/sadc_top_sva.sv ----
// Checker for the serial converter control block top.
// Assumes it is bound to sadc_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module sadc_top_sva (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_BREADY,
  input wire logic O_BVALID,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_CHIP_SELECT_N,
  input wire logic I_SERIAL_CLOCK,
  input wire logic O_SERIAL_OUT,
  input wire logic O_SERIAL_OUT_OE_N,
  input wire logic I_SHUTDOWN_INPUT_LOW,
  input wire logic I_SHUTDOWN_INPUT_HIGH,
  input wire logic O_SHUTDOWN,
  input wire logic O_REF_INTERNAL_COMP,
  input wire logic O_TRACK_HOLD
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  ////////////////////////////////////////////////////////////////////////////
  a_dout_tristate: assert property (I_CHIP_SELECT_N [*4] |-> O_SERIAL_OUT_OE_N)
    else $error("data output driven while deselected");
  a_dout_stable: assert property (I_SERIAL_CLOCK [*3] |-> $stable(O_SERIAL_OUT))
    else $error("data output moved in clock high phase");
  a_shutdown_input_enter: assert property (I_SHUTDOWN_INPUT_LOW [*4] |-> O_SHUTDOWN)
    else $error("shutdown not entered");
  a_shutdown_input_leave: assert property (!I_SHUTDOWN_INPUT_LOW [*4] |-> !O_SHUTDOWN)
    else $error("shut down without low input");
  a_ref_internal: assert property
    ((I_SHUTDOWN_INPUT_HIGH && !I_SHUTDOWN_INPUT_LOW) [*4] |-> O_REF_INTERNAL_COMP)
    else $error("internal compensation not chosen");
  a_ref_external: assert property
    ((!I_SHUTDOWN_INPUT_HIGH && !I_SHUTDOWN_INPUT_LOW) [*4] |-> !O_REF_INTERNAL_COMP)
    else $error("external compensation not chosen");
  a_track_select: assert property ($rose(O_TRACK_HOLD) |-> !$past(I_CHIP_SELECT_N, 3))
    else $error("tracking started while deselected");
  a_rd_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_rd_release: assert property (O_RVALID && I_RREADY |=> !O_RVALID && O_ARREADY)
    else $error("read channel not released");
  a_wr_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response not released");
endmodule

bind sadc_top sadc_top_sva chk_u (.I_CLK(I_CLK), .I_RST(I_RST), .I_BREADY(I_BREADY),
  .O_BVALID(O_BVALID), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .I_CHIP_SELECT_N(I_CHIP_SELECT_N), .I_SERIAL_CLOCK(I_SERIAL_CLOCK),
  .O_SERIAL_OUT(O_SERIAL_OUT), .O_SERIAL_OUT_OE_N(O_SERIAL_OUT_OE_N),
  .I_SHUTDOWN_INPUT_LOW(I_SHUTDOWN_INPUT_LOW), .I_SHUTDOWN_INPUT_HIGH(I_SHUTDOWN_INPUT_HIGH),
  .O_SHUTDOWN(O_SHUTDOWN), .O_REF_INTERNAL_COMP(O_REF_INTERNAL_COMP),
  .O_TRACK_HOLD(O_TRACK_HOLD));
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the serial converter control block.
// Assumes sadc_top, the host model and the bound checker are compiled.
`timescale 1ns/10ps
`default_nettype none
`include "sadc_defs.vh"

module testbench;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic shutdown_input_lo = 0, shutdown_input_hi = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'h1;
  logic [9:0] tgt = 0;
  logic [1:0] r;
  wire logic cs_n, sclk, din, awready, wready, bvalid, arready, rvalid, irq, dout, dout_oe_n;
  wire logic strb, strb_oe_n, shut, refint, track, uni, sgl;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0] chan;
  wire logic [9:0] dac;
  // Comparator of an ideal input at tgt
  wire logic comp = (dac <= tgt);
  int mismatches = 0, checks_done = 0;

  always #12.5 clk = ~clk;

  sadc_top #(.STEP_CYCLES(4)) dut_u (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_IRQ(irq),
    .I_CHIP_SELECT_N(cs_n), .I_SERIAL_CLOCK(sclk), .I_SERIAL_IN(din), .O_SERIAL_OUT(dout),
    .O_SERIAL_OUT_OE_N(dout_oe_n), .O_CONVERSION_STROBE(strb),
    .O_CONVERSION_STROBE_OE_N(strb_oe_n), .I_SHUTDOWN_INPUT_LOW(shutdown_input_lo),
    .I_SHUTDOWN_INPUT_HIGH(shutdown_input_hi), .I_COMPARATOR(comp), .O_SHUTDOWN(shut),
    .O_REF_INTERNAL_COMP(refint), .O_TRACK_HOLD(track), .O_CHANNEL_SELECT(chan),
    .O_UNIPOLAR(uni), .O_SINGLE_ENDED(sgl), .O_DAC_CODE(dac));
  sadc_host host_u (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe_n(dout_oe_n), .strb(strb), .strb_oe_n(strb_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    begin
      checks_done++;
      if (g !== e)
      begin
        mismatches++;
        $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
      end
    end
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    begin
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (n < 100)
      begin
        @(posedge clk);
        n++;
        if (awvalid && awready)
          awvalid <= 1'h0;
        if (wvalid && wready)
          wvalid <= 1'h0;
        if (bvalid)
          break;
      end
      rs = bresp;
      bready <= 1'h0;
      chk(n < 100, 1'h1, "write hang");
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string m);
    int n;
    begin
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (n < 100)
      begin
        @(posedge clk);
        n++;
        if (arvalid && arready)
          arvalid <= 1'h0;
        if (rvalid)
          break;
      end
      rready <= 1'h0;
      chk(n < 100, 1'h1, "read hang");
      chk(rdata, e, m);
      chk(rresp, er, m);
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    begin
      rd_chk(`SADC_ADDR_CTRL, 1'h1, `SADC_RESP_OKAY, "ctrl reset");
      rd_chk(`SADC_ADDR_INT_MASK, 3'h0, `SADC_RESP_OKAY, "mask reset");
      rd_chk(8'h14, 32'h0000_0000, `SADC_RESP_SLVERR, "unmapped read");
      axi_wr(8'h14, 32'h0000_0001, r);
      chk(r, `SADC_RESP_SLVERR, "unmapped write");
      axi_wr(`SADC_ADDR_INT_MASK, 32'h0000_0003, r);
      rd_chk(`SADC_ADDR_INT_MASK, 3'h3, `SADC_RESP_OKAY, "mask");
      wstrb <= 4'h0;
      axi_wr(`SADC_ADDR_INT_MASK, 32'h0000_0000, r);
      wstrb <= 4'h1;
      chk(r, `SADC_RESP_OKAY, "lane off write");
      rd_chk(`SADC_ADDR_INT_MASK, 3'h3, `SADC_RESP_OKAY, "lane off kept");
      $display("test regs done");
    end
  endtask

  task t_int;
    logic q, s;
    logic [7:0] cb;
    logic [9:0] res;
    int n;
    begin
      cb = 8'hDE;
      tgt = 10'h2C5;
      n = 0;
      host_u.cs(1'h0);
      for (int i = 0; i < 8; i++)
      begin
        host_u.cyc(cb[7-i], q, s);
        if (i == 4)
          chk(track, 1'h0, "track early");
        if (i == 5)
          chk(track, 1'h1, "track");
      end
      while (strb !== 1'h0 && n < 20)
      begin
        @(posedge clk);
        n++;
      end
      n = 0;
      while (strb !== 1'h1 && n < 200)
      begin
        @(posedge clk);
        n++;
      end
      // Ten steps of four cycles, small slack for start and finish
      chk(n >= 40 && n <= 43, 1'h1, "conversion time");
      chk(track, 1'h0, "hold");
      chk({chan, uni, sgl}, 5'h17, "fields");
      repeat (2) @(posedge clk);
      chk(irq, 1'h1, "irq raised");
      rd_chk(`SADC_ADDR_INT_STATUS, 3'h3, `SADC_RESP_OKAY, "int status");
      repeat (2) @(posedge clk);
      chk(irq, 1'h0, "irq cleared");
      rd_chk(`SADC_ADDR_RESULT, tgt, `SADC_RESP_OKAY, "result");
      host_u.cs(1'h0);
      for (int i = 0; i < 10; i++)
      begin
        host_u.cyc(1'h0, q, s);
        res = {res[8:0], q};
      end
      chk(res, tgt, "serial result");
      host_u.cs(1'h1);
      $display("test internal done");
    end
  endtask

  task t_ext;
    logic q, s;
    logic [7:0] cb;
    logic [9:0] res;
    logic [20:0] sv;
    begin
      cb = 8'hA3;
      tgt = 10'h13A;
      host_u.cs(1'h0);
      for (int i = 0; i < 29; i++)
      begin
        host_u.cyc(i < 8 ? cb[7-i] : 1'h0, q, s);
        if (i >= 8)
          sv = {sv[19:0], s};
        if (i >= 19)
          res = {res[8:0], q};
      end
      chk(sv, 21'h10_0000, "strobe pulse");
      chk(res, tgt, "paced result");
      chk({chan, uni, sgl}, 5'h08, "ext fields");
      host_u.cs(1'h1);
      repeat (6) @(posedge clk);
      chk({dout_oe_n, strb_oe_n}, 2'h3, "released");
      $display("test external done");
    end
  endtask

  task t_ign;
    logic q, s;
    logic [7:0] cb;
    begin
      cb = 8'hF2;
      rd_chk(`SADC_ADDR_INT_STATUS, 3'h3, `SADC_RESP_OKAY, "ext status");
      host_u.cs(1'h1);
      // Second byte is selected but the link is disabled by software
      for (int i = 0; i < 16; i++)
      begin
        if (i == 8)
        begin
          axi_wr(`SADC_ADDR_CTRL, 32'h0000_0000, r);
          host_u.cs(1'h0);
        end
        host_u.cyc(cb[7-i%8], q, s);
      end
      host_u.cs(1'h1);
      axi_wr(`SADC_ADDR_CTRL, 32'h0000_0001, r);
      repeat (8) @(posedge clk);
      chk(chan, 3'h2, "deselected byte");
      rd_chk(`SADC_ADDR_INT_STATUS, 3'h0, `SADC_RESP_OKAY, "no byte");
      $display("test ignore done");
    end
  endtask

  task t_shutdown_input;
    begin
      shutdown_input_lo <= 1'h1;
      repeat (6) @(posedge clk);
      chk(shut, 1'h1, "shutdown");
      chk(irq, 1'h0, "masked irq");
      rd_chk(`SADC_ADDR_INT_STATUS, 3'h4, `SADC_RESP_OKAY, "shutdown_input status");
      rd_chk(`SADC_ADDR_STATUS, 32'h0000_042C, `SADC_RESP_OKAY, "status word");
      shutdown_input_lo <= 1'h0;
      repeat (6) @(posedge clk);
      chk({shut, refint}, 2'h1, "high level");
      shutdown_input_hi <= 1'h0;
      repeat (6) @(posedge clk);
      chk({shut, refint}, 2'h0, "floating");
      shutdown_input_hi <= 1'h1;
      $display("test shutdown done");
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    t_regs;
    t_int;
    t_ext;
    t_ign;
    t_shutdown_input;
    wrap_up;
  end

  initial
  begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule
`default_nettype wire
